// ---- verilog/bu_serial_pll.sv ----
// Band unit control: latched serial control outputs, synthesizer
// dividers, lock detection and transmit supply gating.
// Assumes the shift clock only runs while the control unit sends a word
// and that all other inputs except core_clk and srst are asynchronous pins.
`timescale 1ns/1ps

// Overview of operation
// - Control unit shifts configuration over three wires
// - First output low selects transmit
// - Eighth output high selects transmit
// - Two outputs encode high, middle, low power
// - Off band: fourth low, fifth high
// - Seventh output drives receive attenuator
// - Sixth output high AM, low FM
// - Reference divides by 2210 or 1857 until a frame sets the ratio
// - VCO ratio is n times 64 plus A
// - Reference ratio held in 16-bit counter
// - Lock output high while locked only
// - Synthesizer told transmit or receive direction
// - Transmit supply on only with first output low
// - Lock loss forces transmit supply off
module bu_serial_pll
  import bu_pkg::*;
(
  input  wire logic core_clk,           // 125 MHz core clock
  input  wire logic srst,               // Synchronous reset, active high
  input  wire logic serialShiftClock,   // Link shift clock pin
  input  wire logic serialDataLine,     // Link serial data pin
  input  wire logic latchStrobeLine,    // Link latch strobe pin
  input  wire logic bandIs50,           // Strap: 11.05 MHz reference fitted
  input  wire logic synthSerialData,    // Synthesizer data pin
  input  wire logic synthSerialClock,   // Synthesizer clock pin
  input  wire logic synthSerialEnable,  // Synthesizer enable pin
  input  wire logic vcoFeedback,        // VCO output, divider input
  output logic      txSelectActiveLow,  // Low while transmit chosen
  output logic      powerHighSelect,    // High power select
  output logic      powerMiddleSelect,  // Middle power select
  output logic      inBandFlag,         // Low while off band
  output logic      offBandFlag,        // High while off band
  output logic      amFmSelect,         // High AM, low FM
  output logic      attenuatorOn,       // Receive attenuator on
  output logic      txSelectActiveHigh, // High while transmit chosen
  output logic      pllLockDetect,      // Loop locked
  output logic      synthTxIndicate,    // Synthesizer direction
  output logic      switchedTxSupply,   // Transmit supply enable
  output logic      synthProgrammed,    // Frame loaded since reset
  output logic      compareTick         // Comparison frequency pulse
);

  // ---------------------------------------------------------------
  // Link domain: the shift stage runs on the control unit's clock
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] shiftWord;

  bu_link_shift u_link_shift (
    .serialShiftClock (serialShiftClock),
    .serialDataLine   (serialDataLine),
    .shiftWord        (shiftWord)
  );

  // ---------------------------------------------------------------
  // Crossing of the shift word and the strobe into the core domain
  // ---------------------------------------------------------------
  // The shift stage is quiet while the strobe is high, so a word that
  // has passed two flip-flops and then held for one more cycle is safe
  // to latch; a word still moving is simply not taken that cycle.
  logic [CTRL_W-1:0] wordMeta_ff;
  logic [CTRL_W-1:0] wordSync_ff;
  logic [CTRL_W-1:0] wordPrev_ff;
  logic              strobeMeta_ff;
  logic              strobeSync_ff;

  always_ff @(posedge core_clk)
  begin
    wordMeta_ff   <= shiftWord;
    wordSync_ff   <= wordMeta_ff;
    wordPrev_ff   <= wordSync_ff;
    strobeMeta_ff <= latchStrobeLine;
    strobeSync_ff <= strobeMeta_ff;
  end

  wire wordStable = (wordSync_ff == wordPrev_ff);
  wire latchOpen  = strobeSync_ff && wordStable;

  // ---------------------------------------------------------------
  // Output latch: transparent while the strobe is high
  // ---------------------------------------------------------------
  bu_ctrl_t ctrl_ff;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      ctrl_ff <= bu_ctrl_t'(CTRL_RST);
    else if (latchOpen)
      ctrl_ff <= bu_ctrl_t'(wordPrev_ff);
  end

  assign txSelectActiveLow  = ctrl_ff.txSelectActiveLow;
  assign powerHighSelect    = ctrl_ff.powerHighSelect;
  assign powerMiddleSelect  = ctrl_ff.powerMiddleSelect;
  assign inBandFlag         = ctrl_ff.inBandFlag;
  assign offBandFlag        = ctrl_ff.offBandFlag;
  assign amFmSelect         = ctrl_ff.amFmSelect;
  assign attenuatorOn       = ctrl_ff.attenuatorOn;
  assign txSelectActiveHigh = ctrl_ff.txSelectActiveHigh;

  // ---------------------------------------------------------------
  // Reference strap, caught once after reset release
  // ---------------------------------------------------------------
  logic bandMeta_ff;
  logic bandSync_ff;
  logic band50_ff;
  logic strapTaken_ff;

  always_ff @(posedge core_clk)
  begin
    bandMeta_ff <= bandIs50;
    bandSync_ff <= bandMeta_ff;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      band50_ff     <= 1'b0;
      strapTaken_ff <= 1'b0;
    end
    else if (!strapTaken_ff)
    begin
      band50_ff     <= bandSync_ff;
      strapTaken_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Synthesizer programming port: data, clock and enable pins
  // ---------------------------------------------------------------
  logic [2:0] synMeta_ff;
  logic [2:0] synSync_ff;
  logic [2:0] synPrev_ff;

  always_ff @(posedge core_clk)
  begin
    synMeta_ff <= {synthSerialEnable, synthSerialClock, synthSerialData};
    synSync_ff <= synMeta_ff;
    synPrev_ff <= synSync_ff;
  end

  wire synClkRise = bu_rise(synSync_ff[1], synPrev_ff[1]);
  wire synEnRise  = bu_rise(synSync_ff[2], synPrev_ff[2]);

  logic [SYNTH_W-1:0] synShift_ff;
  bu_synth_word_t     synWord_ff;
  logic               synLoaded_ff;

  always_ff @(posedge core_clk)
  begin
    if (srst)
      synShift_ff <= '0;
    else if (synClkRise)
      synShift_ff <= {synShift_ff[SYNTH_W-2:0], synSync_ff[0]};
  end

  // A frame takes effect on the enable edge; counters restart with it
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      synWord_ff   <= '0;
      synLoaded_ff <= 1'b0;
    end
    else if (synEnRise)
    begin
      synWord_ff   <= bu_synth_word_t'(synShift_ff);
      synLoaded_ff <= 1'b1;
    end
  end

  assign synthProgrammed = synLoaded_ff;

  // ---------------------------------------------------------------
  // Reference divider
  // ---------------------------------------------------------------
  // Until a frame arrives the ratio follows the fitted crystal, so the
  // comparison frequency is right from the start.
  wire [REF_W-1:0] refDefault = band50_ff ? REF_DIV_11050
                                          : REF_DIV_9285;
  wire [REF_W-1:0] refRatio   = synLoaded_ff ? synWord_ff.refDiv
                                             : refDefault;
  wire [REF_W-1:0] refLast    = refRatio - 16'h0001;

  logic [REF_W-1:0] refCnt_ff;
  logic             refTick_ff;

  wire refWrap = (refCnt_ff >= refLast);

  always_ff @(posedge core_clk)
  begin
    if (srst || synEnRise)
      refCnt_ff <= '0;
    else
      refCnt_ff <= refWrap ? '0 : refCnt_ff + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      refTick_ff <= 1'b0;
    else
      refTick_ff <= refWrap && !synEnRise;
  end

  assign compareTick = refTick_ff;

  // ---------------------------------------------------------------
  // VCO divider: dual-modulus prescaler with swallow counter
  // ---------------------------------------------------------------
  // A cycles of 65 followed by n-A cycles of 64 give n*64+A in all.
  // The programmed n must not be less than A, as with any swallow divider.
  logic vcoMeta_ff;
  logic vcoSync_ff;
  logic vcoPrev_ff;

  always_ff @(posedge core_clk)
  begin
    vcoMeta_ff <= vcoFeedback;
    vcoSync_ff <= vcoMeta_ff;
    vcoPrev_ff <= vcoSync_ff;
  end

  wire vcoEdge = bu_rise(vcoSync_ff, vcoPrev_ff);

  logic [PRESC_W-1:0] prescCnt_ff;
  logic [SWAL_W-1:0]  swalRem_ff;
  logic [PROG_W-1:0]  progCnt_ff;
  logic               vcoDivTick_ff;

  wire               swalActive = (swalRem_ff != '0);
  wire [PRESC_W-1:0] prescLastV = swalActive ? PRESC_LAST_HIGH
                                             : PRESC_LAST_LOW;
  wire               prescLast  = vcoEdge && (prescCnt_ff == prescLastV);
  wire [PROG_W-1:0]  progLastV  = synWord_ff.progN - 10'h001;
  wire               progLast   = prescLast && (progCnt_ff == progLastV);

  always_ff @(posedge core_clk)
  begin
    if (srst || synEnRise)
      prescCnt_ff <= '0;
    else if (vcoEdge)
      prescCnt_ff <= prescLast ? '0 : prescCnt_ff + 7'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst || synEnRise)
      swalRem_ff <= '0;
    else if (progLast)
      swalRem_ff <= synWord_ff.swallowA;
    else if (prescLast && swalActive)
      swalRem_ff <= swalRem_ff - 6'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst || synEnRise)
      progCnt_ff <= '0;
    else if (progLast)
      progCnt_ff <= '0;
    else if (prescLast)
      progCnt_ff <= progCnt_ff + 10'h001;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      vcoDivTick_ff <= 1'b0;
    else
      vcoDivTick_ff <= progLast;
  end

  // ---------------------------------------------------------------
  // Lock detector
  // ---------------------------------------------------------------
  // A comparison period is good when exactly one divided VCO pulse
  // falls in it. One bad period drops lock at once; several good ones
  // in a row are needed to regain it, which keeps a slipping loop from
  // flickering the transmit supply on.
  logic [1:0]     perCnt_ff;
  logic [2:0]     runCnt_ff;
  bu_lock_state_t lockState_ff;
  bu_lock_state_t nxt_lockState;
  logic           pllLock_ff;

  wire [1:0] perNext    = (vcoDivTick_ff && perCnt_ff != 2'h3)
                          ? perCnt_ff + 2'h1 : perCnt_ff;
  wire       goodPeriod = refTick_ff && (perNext == 2'h1);
  wire       badPeriod  = refTick_ff && (perNext != 2'h1);
  wire       runDone    = (runCnt_ff == LOCK_PERIODS - 3'h1);

  always_ff @(posedge core_clk)
  begin
    if (srst || synEnRise)
      perCnt_ff <= '0;
    else
      perCnt_ff <= refTick_ff ? 2'h0 : perNext;
  end

  always_comb
  begin
    nxt_lockState = lockState_ff;
    unique case (lockState_ff)
      LOCK_IDLE:
        if (goodPeriod)
          nxt_lockState = LOCK_ACQ;
      LOCK_ACQ:
        if (badPeriod)
          nxt_lockState = LOCK_IDLE;
        else if (goodPeriod && runDone)
          nxt_lockState = LOCK_HOLD;
      LOCK_HOLD:
        if (badPeriod)
          nxt_lockState = LOCK_IDLE;
      default:
        nxt_lockState = LOCK_IDLE;
    endcase
    if (synEnRise)
      nxt_lockState = LOCK_IDLE;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      lockState_ff <= LOCK_IDLE;
    else
      lockState_ff <= nxt_lockState;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst || nxt_lockState == LOCK_IDLE)
      runCnt_ff <= 3'h1;
    else if (goodPeriod && lockState_ff == LOCK_ACQ)
      runCnt_ff <= runCnt_ff + 3'h1;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      pllLock_ff <= 1'b0;
    else
      pllLock_ff <= (nxt_lockState == LOCK_HOLD);
  end

  assign pllLockDetect = pllLock_ff;

  // ---------------------------------------------------------------
  // Transmit direction and supply gating
  // ---------------------------------------------------------------
  logic synthTx_ff;
  logic txSupply_ff;

  wire txChosen = !ctrl_ff.txSelectActiveLow;

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      synthTx_ff  <= 1'b0;
      txSupply_ff <= 1'b0;
    end
    else
    begin
      synthTx_ff  <= txChosen;
      txSupply_ff <= txChosen
                     && (nxt_lockState == LOCK_HOLD);
    end
  end

  assign synthTxIndicate  = synthTx_ff;
  assign switchedTxSupply = txSupply_ff;

endmodule // bu_serial_pll

// ---- verilog/bu_pkg.sv ----
// Shared constants, field layouts and state codes of the band unit control.
// Assumes a 125 MHz core clock; the shift clock arrives on its own pin.
package bu_pkg;

  // Widths of the serial words and divider fields
  localparam int CTRL_W  = 8;
  localparam int SYNTH_W = 32;
  localparam int REF_W   = 16;
  localparam int PROG_W  = 10;
  localparam int SWAL_W  = 6;
  localparam int PRESC_W = 7;

  // Core clock, reference and comparison figures
  localparam int CORE_CLK_KHZ  = 125000;
  localparam int REF_OSC_KHZ_A = 9285;
  localparam int REF_OSC_KHZ_B = 11050;
  localparam int COMPARE_KHZ   = 5;

  // Reference divide ratios for the two crystal options
  localparam logic [REF_W-1:0] REF_DIV_9285  = 16'h0741;
  localparam logic [REF_W-1:0] REF_DIV_11050 = 16'h08A2;

  // Dual-modulus prescaler: last count of the divide-by-64 and -65 cycles
  localparam logic [PRESC_W-1:0] PRESC_LAST_LOW  = 7'h3F;
  localparam logic [PRESC_W-1:0] PRESC_LAST_HIGH = 7'h40;

  // Parallel outputs after reset: receive selected, in band, rest low
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h09;

  // Good comparison periods in a row before lock is reported
  localparam logic [2:0] LOCK_PERIODS = 3'h4;

  // Parallel output word; bit 0 is the first output, bit 7 the eighth
  typedef struct packed {
    logic txSelectActiveHigh;
    logic attenuatorOn;
    logic amFmSelect;
    logic offBandFlag;
    logic inBandFlag;
    logic powerMiddleSelect;
    logic powerHighSelect;
    logic txSelectActiveLow;
  } bu_ctrl_t;

  // Synthesizer programming frame, sent most significant bit first
  typedef struct packed {
    logic [REF_W-1:0]  refDiv;
    logic [PROG_W-1:0] progN;
    logic [SWAL_W-1:0] swallowA;
  } bu_synth_word_t;

  typedef enum logic [2:0] {
    LOCK_IDLE = 3'b001,
    LOCK_ACQ  = 3'b010,
    LOCK_HOLD = 3'b100
  } bu_lock_state_t;

  // Rising edge of a synchronised level against its previous sample
  function automatic logic bu_rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

endpackage

// ---- verilog/bu_link_shift.sv ----
// Serial shift stage clocked by the control unit's shift clock.
// Assumes data is stable around each rising edge of that clock.
`timescale 1ns/1ps
module bu_link_shift
  import bu_pkg::*;
(
  input  wire logic              serialShiftClock, // Link shift clock
  input  wire logic              serialDataLine,   // Serial data in
  output logic      [CTRL_W-1:0] shiftWord         // Shift stage contents
);

  logic [CTRL_W-1:0] shift_ff;

  // No reset: the link clock may stand still, and the stage only holds
  // data; nothing reaches the outputs until the strobe latches it.
  always_ff @(posedge serialShiftClock)
  begin
    shift_ff <= {shift_ff[CTRL_W-2:0], serialDataLine};
  end

  assign shiftWord = shift_ff;

endmodule // bu_link_shift

// ---- dv/bu_serial_pll_assertions.sv ----
// Port checker of the band unit control, core clock domain only.
// Bound to bu_serial_pll; sees nothing but its ports.
`timescale 1ns/1ps
module bu_serial_pll_assertions
  import bu_pkg::*;
(
  input wire logic core_clk,           // Core clock
  input wire logic srst,               // Synchronous reset
  input wire logic latchStrobeLine,    // Link strobe pin
  input wire logic bandIs50,           // Crystal strap
  input wire logic synthSerialEnable,  // Frame enable pin
  input wire logic txSelectActiveLow,  // First output
  input wire logic powerHighSelect,    // Second output
  input wire logic powerMiddleSelect,  // Third output
  input wire logic inBandFlag,         // Fourth output
  input wire logic offBandFlag,        // Fifth output
  input wire logic amFmSelect,         // Sixth output
  input wire logic attenuatorOn,       // Seventh output
  input wire logic txSelectActiveHigh, // Eighth output
  input wire logic pllLockDetect,      // Lock flag
  input wire logic synthTxIndicate,    // Direction to synthesizer
  input wire logic switchedTxSupply,   // Transmit supply
  input wire logic compareTick         // Comparison pulse
);
  bu_ctrl_t    ctrlWord;
  logic [15:0] gap_ff;
  logic        seenTick_ff;
  logic        framed_ff;
  wire  [15:0] nxt_gap = compareTick ? 16'h0001 : gap_ff + 16'h0001;

  assign ctrlWord = {txSelectActiveHigh, attenuatorOn, amFmSelect,
                     offBandFlag, inBandFlag, powerMiddleSelect,
                     powerHighSelect, txSelectActiveLow};

  // Ratio check only until a frame may have replaced the strap default
  always_ff @(posedge core_clk)
  begin
    gap_ff      <= nxt_gap;
    seenTick_ff <= !srst && (seenTick_ff || compareTick);
    framed_ff   <= !srst && (framed_ff || synthSerialEnable);
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  reset_values_a: assert property (disable iff (1'b0)
    srst |=> ctrlWord == CTRL_RST && !pllLockDetect && !synthTxIndicate
             && !switchedTxSupply && !compareTick)
    else $error("outputs not at reset values");
  hold_outputs_a: assert property (
    !latchStrobeLine [*7] |-> $stable(ctrlWord))
    else $error("outputs moved without strobe");
  supply_gate_a: assert property (
    switchedTxSupply == (pllLockDetect && !$past(txSelectActiveLow)))
    else $error("transmit supply not gated by select and lock");
  lock_loss_a: assert property (
    $fell(pllLockDetect) |-> !switchedTxSupply)
    else $error("supply stayed on after lock loss");
  tx_indicate_a: assert property (
    $fell(txSelectActiveLow) |-> ##[0:1] synthTxIndicate)
    else $error("synthesizer not told of transmit");
  rx_indicate_a: assert property (
    $rose(txSelectActiveLow) |-> ##[0:1] !synthTxIndicate)
    else $error("synthesizer not told of receive");
  tick_pulse_a: assert property (
    compareTick |=> !compareTick)
    else $error("comparison pulse longer than one cycle");
  ref_ratio_a: assert property (
    compareTick && seenTick_ff && !framed_ff
      |-> gap_ff == (bandIs50 ? 16'h08A2 : 16'h0741))
    else $error("comparison period wrong for strap");

  cover property ($rose(switchedTxSupply));
  cover property ($fell(pllLockDetect));
  cover property (compareTick && seenTick_ff && !framed_ff);
endmodule // bu_serial_pll_assertions

bind bu_serial_pll bu_serial_pll_assertions u_chk (.core_clk, .srst,
  .latchStrobeLine, .bandIs50, .synthSerialEnable, .txSelectActiveLow,
  .powerHighSelect, .powerMiddleSelect, .inBandFlag, .offBandFlag,
  .amFmSelect, .attenuatorOn, .txSelectActiveHigh, .pllLockDetect,
  .synthTxIndicate, .switchedTxSupply, .compareTick);

// ---- dv/bu_ctrl_unit_model.sv ----
// Model of the main control unit: link words and synthesizer frames.
// Tasks are called by the bench; core_clk paces strobe and frame pins.
`timescale 1ns/1ps
module bu_ctrl_unit_model
  import bu_pkg::*;
(
  input  wire logic core_clk,          // Core clock
  output logic      serialShiftClock,  // Link shift clock
  output logic      serialDataLine,    // Link data
  output logic      latchStrobeLine,   // Link strobe
  output logic      synthSerialData,   // Frame data
  output logic      synthSerialClock,  // Frame clock
  output logic      synthSerialEnable  // Frame enable
);
  initial
  begin
    serialShiftClock  = 1'b0;
    serialDataLine    = 1'b0;
    latchStrobeLine   = 1'b0;
    synthSerialData   = 1'b0;
    synthSerialClock  = 1'b0;
    synthSerialEnable = 1'b0;
  end

  // Eighth output bit goes first; shift clock only runs inside a word
  task automatic send_word(input bu_ctrl_t w, input bit latch);
    int i;
    #1.7;
    for (i = CTRL_W - 1; i >= 0; i--)
    begin
      serialDataLine = w[i];
      #3 serialShiftClock = 1'b1;
      #3 serialShiftClock = 1'b0;
    end
    // Released line must not keep showing the last bit
    serialDataLine = ~serialDataLine;
    repeat (5) @(posedge core_clk);
    if (latch)
    begin
      latchStrobeLine <= 1'b1;
      repeat (8) @(posedge core_clk);
      latchStrobeLine <= 1'b0;
    end
  endtask

  // Pins held four core cycles per level, well above the sync need
  task automatic send_frame(input bu_synth_word_t f);
    int i;
    for (i = SYNTH_W - 1; i >= 0; i--)
    begin
      synthSerialData <= f[i];
      repeat (4) @(posedge core_clk);
      synthSerialClock <= 1'b1;
      repeat (4) @(posedge core_clk);
      synthSerialClock <= 1'b0;
    end
    synthSerialData   <= ~f[0];
    synthSerialEnable <= 1'b1;
    repeat (4) @(posedge core_clk);
    synthSerialEnable <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
endmodule // bu_ctrl_unit_model

// ---- dv/bu_serial_pll_tb.sv ----
// Self-checking bench of the band unit control.
// Control unit model drives the link; the bench drives strap and VCO.
`timescale 1ns/1ps
module bu_serial_pll_tb
  import bu_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic bandIs50 = 1'b0;
  logic vcoRun = 1'b0;
  logic [1:0] vcoDiv = 2'h0;
  wire  vcoFeedback = vcoDiv[1];
  logic serialShiftClock, serialDataLine, latchStrobeLine;
  logic synthSerialData, synthSerialClock, synthSerialEnable;
  logic txSelectActiveLow, powerHighSelect, powerMiddleSelect, inBandFlag;
  logic offBandFlag, amFmSelect, attenuatorOn, txSelectActiveHigh;
  logic pllLockDetect, synthTxIndicate, switchedTxSupply;
  logic synthProgrammed, compareTick;
  bu_ctrl_t ctrlOut, lastCtrl, expC;
  bu_ctrl_t lastExp = 8'h09;
  bu_ctrl_t expQ[$];
  int n_errors = 0;
  int compares = 0;
  int n;
  integer seed = 65474;

  always #4 core_clk = ~core_clk;
  // VCO of four core cycles, stands still when stopped
  always @(posedge core_clk)
    if (vcoRun)
      vcoDiv <= vcoDiv + 2'h1;

  bu_ctrl_unit_model i_ctrl (.core_clk, .serialShiftClock,
    .serialDataLine, .latchStrobeLine, .synthSerialData,
    .synthSerialClock, .synthSerialEnable);
  bu_serial_pll i_dut (.core_clk, .srst, .serialShiftClock,
    .serialDataLine, .latchStrobeLine, .bandIs50, .synthSerialData,
    .synthSerialClock, .synthSerialEnable, .vcoFeedback,
    .txSelectActiveLow, .powerHighSelect, .powerMiddleSelect, .inBandFlag,
    .offBandFlag, .amFmSelect, .attenuatorOn, .txSelectActiveHigh,
    .pllLockDetect, .synthTxIndicate, .switchedTxSupply, .synthProgrammed,
    .compareTick);

  assign ctrlOut = {txSelectActiveHigh, attenuatorOn, amFmSelect,
                    offBandFlag, inBandFlag, powerMiddleSelect,
                    powerHighSelect, txSelectActiveLow};

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Any output change takes the oldest note; none noted means none allowed
  always @(posedge core_clk)
  begin
    if (!srst && ctrlOut !== lastCtrl)
    begin
      expC = expQ.size() ? expQ.pop_front() : lastCtrl;
      check("ctrlOut", expC, ctrlOut);
    end
    lastCtrl <= ctrlOut;
  end

  function automatic bu_ctrl_t enc(input bit tx, input bit [1:0] pwr,
                                   input bit off, input bit am, input bit receive_attenuator);
    bu_ctrl_t c;
    c.txSelectActiveLow  = !tx;
    c.txSelectActiveHigh = tx;
    c.powerHighSelect    = (pwr == 2);
    c.powerMiddleSelect  = (pwr == 1);
    c.inBandFlag         = !off;
    c.offBandFlag        = off;
    c.amFmSelect         = am;
    c.attenuatorOn       = receive_attenuator;
    return c;
  endfunction

  task automatic sendw(input bu_ctrl_t w, input bit latch);
    if (w == lastExp)
      w = ~w;
    if (latch)
    begin
      expQ.push_back(w);
      lastExp = w;
    end
    i_ctrl.send_word(w, latch);
  endtask

  task automatic waitSig(input bit lockSel, input logic lvl, output int k);
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while ((lockSel ? pllLockDetect : compareTick) !== lvl && k < 5000);
  endtask

  initial
  begin
    for (int b = 0; b < 2; b++)
    begin
      srst     <= 1'b1;
      bandIs50 <= b[0];
      repeat (20) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      check("ctrlOut", enc(0, 0, 0, 0, 0), ctrlOut);
      check("programmed", 1'b0, synthProgrammed);
      waitSig(0, 1'b1, n);
      waitSig(0, 1'b1, n);
      check("refPeriod", b ? 16'h08A2 : 16'h0741, 16'(n));
    end
    sendw(enc(1, 2, 0, 0, 0), 1);
    sendw(enc(1, 1, 0, 1, 1), 1);
    sendw(enc(1, 0, 1, 0, 1), 1);
    sendw(enc(0, 0, 1, 1, 0), 0);
    sendw(enc(0, 2, 0, 1, 1), 1);
    repeat (6)
      sendw(bu_ctrl_t'(8'($random(seed))), 1);
    sendw(enc(0, 0, 0, 0, 0), 1);
    // R 516, n 2, A 1: ratio 129 of a four-cycle VCO gives one per period
    i_ctrl.send_frame({16'h0204, 10'h002, 6'h01});
    check("programmed", 1'b1, synthProgrammed);
    vcoRun <= 1'b1;
    waitSig(0, 1'b1, n);
    waitSig(0, 1'b1, n);
    check("refPeriod", 16'h0204, 16'(n));
    waitSig(1, 1'b1, n);
    check("lock", 1'b1, pllLockDetect);
    sendw(enc(1, 2, 0, 0, 0), 1);
    repeat (4) @(posedge core_clk);
    check("txSupply", 1'b1, switchedTxSupply);
    check("txIndicate", 1'b1, synthTxIndicate);
    vcoRun <= 1'b0;
    waitSig(1, 1'b0, n);
    check("unlockFast", 1'b1, n < 1100);
    check("txSupply", 1'b0, switchedTxSupply);
    repeat (4) @(posedge core_clk);
    check("queueEmpty", 16'h0000, 16'(expQ.size()));
    end_sim();
  end

  initial
  begin
    #200000;
    n_errors++;
    end_sim();
  end
endmodule // bu_serial_pll_tb
